// file: rtl/idr_regs.sv
// register bank: address match, frame length, ms timer, c/i and s/q channels
//
// The implementer's own choice: register access over AXI4-Lite.
`include "idr_consts.svh"

// Behaviour
// - first address byte matched against two choices, second byte against two more
// - second-byte mask bit 1 drops that bit from both second-byte compares
// - second byte always also compared with group endpoint value
// - length overflow set at 8192 bytes of unfinished frame, valid end to acknowledge
// - frame length split high/low, valid from message end until acknowledge
// - timer starts on nonzero write; one-shot stops at zero, repeat reloads
// - expiry pulse each time timer reaches zero, both modes
// - timer pin goes high on start, toggles each half period, idle level when off
// - rewrite before expiry restarts with new count
// - count in ms, 1 to 63; zero write stops timer
// - four-bit ready code, reset 0xC, activation indication in gci mode
// - soft reset bit resets all but bus logic until software writes 0
// - register access other than control register writes inhibited during soft reset; bit is write-only
// - two-bit phase compensation select: none, 260, 520, 1040 ns
// - indication change sets flag; indication register read clears it unless a second code is buffered
// - s-bit change flag only when enabled; multiframe receive read clears it
// - received indication code buffered two entries deep
// - gci mode takes external transceiver indications; s-change flag unused
// - command register drives code to transceiver; reads return last write
// - s bits of frames 1, 6, 11, 16 captured double-buffered
// - q bits sent in frames 1, 6, 11, 16, first q bit in frame 1
module idr_regs
   import idr_pkg::*;
#(
   parameter int TIMER_MS_CYCLES = `IDR_MS_NS / `IDR_CLK_PERIOD_NS
) (
   // clock and reset
   input  wire logic        MCLK,
   input  wire logic        RST,
   // axi4-lite write
   input  wire logic [7:0]  AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic             BVALID,
   output logic [1:0]       BRESP,
   input  wire logic        BREADY,
   // axi4-lite read
   input  wire logic [7:0]  ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic             RVALID,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   input  wire logic        RREADY,
   // d-channel receiver
   input  wire logic        RX_ADDR_VLD,
   input  wire logic [7:0]  RX_ADDR1,
   input  wire logic [7:0]  RX_ADDR2,
   input  wire logic        RX_BYTE,
   input  wire logic        RX_MSG_END,
   input  wire logic        RX_ACK_CMD,
   output logic             ADDR_MATCH,
   output logic             ADDR_MATCH_VLD,
   // layer 1 and gci
   input  wire logic [3:0]  L1_IND,
   input  wire logic [3:0]  GCI_IND,
   input  wire logic        MF_LOCK,
   input  wire logic        MF_STROBE,
   input  wire logic [4:0]  MF_FRAME,
   input  wire logic        S_BIT_IN,
   output logic [3:0]       CMD_CODE,
   output logic             ACT_REQ,
   output logic             LINE_ACTIVE,
   output logic             Q_BIT_OUT,
   // timer, control
   output logic             TIMER_OUT,
   output logic             TIMER_EXPIRED,
   output logic [1:0]       PHASE_COMP_SEL,
   output logic             SOFT_RESET
);
   localparam int HALF_MS = TIMER_MS_CYCLES / 2;

   idr_state_t st;
   idr_state_t d;

   // masked byte compare, zero mask bits take part
   function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
      masked_eq = ((a ^ b) & ~m) == 8'h00;
   endfunction

   // multiframe slot of a frame number: {hit, index}
   function automatic logic [2:0] mf_slot(input logic [4:0] f);
      case (f)
         5'h01:   mf_slot = 3'h4;
         5'h06:   mf_slot = 3'h5;
         5'h0B:   mf_slot = 3'h6;
         5'h10:   mf_slot = 3'h7;
         default: mf_slot = 3'h0;
      endcase
   endfunction

   // core values after hard or soft reset
   function automatic idr_core_t core_reset();
      idr_core_t c;
      c          = '0;
      c.tmr_st   = IDR_TMR_OFF;
      c.rdy_code = `IDR_RST_RDY;
      c.ind_last = `IDR_RST_IND;
      c.ind_cur  = `IDR_RST_IND;
      c.cmd      = `IDR_RST_CMD;
      c.q        = `IDR_RST_Q;
      c.s        = `IDR_RST_S;
      core_reset = c;
   endfunction
   localparam idr_core_t CORE_RST = core_reset();

   logic       wr_go;
   logic       rd_go;
   logic       wen;
   logic [7:0] waddr;
   logic [7:0] raddr;
   logic [7:0] wd;
   logic [7:0] rd;
   logic       rd_hit;
   logic       wr_hit;
   logic       tick;
   logic [6:0] rem_n;
   logic [3:0] ind_src;
   logic [2:0] slot;
   logic [3:0] s_new;

   // next state
   always_comb begin
      d          = st;
      wr_go      = st.b.awready;
      rd_go      = st.b.arready;
      waddr      = {AWADDR[7:2], 2'b00};
      raddr      = {ARADDR[7:2], 2'b00};
      wd         = WDATA[7:0];
      wen        = wr_go & WSTRB[0];
      rd         = 8'h00;
      rd_hit     = 1'b1;
      wr_hit     = 1'b1;
      tick       = 1'b0;
      rem_n      = 7'h00;
      ind_src    = 4'h0;
      slot       = 3'h0;
      s_new      = 4'h0;
      d.c.tmr_exp   = 1'b0;
      d.c.match_vld = 1'b0;

      // write channel: address and data taken together
      d.b.awready = AWVALID & WVALID & ~st.b.awready & ~st.b.bvalid;
      d.b.wready  = AWVALID & WVALID & ~st.b.awready & ~st.b.bvalid;
      if (st.b.bvalid & BREADY) begin
         d.b.bvalid = 1'b0;
      end
      // read channel
      d.b.arready = ARVALID & ~st.b.arready & ~st.b.rvalid;
      if (st.b.rvalid & RREADY) begin
         d.b.rvalid = 1'b0;
      end

      // timer countdown in half-ms steps
      if (st.c.tmr_st == IDR_TMR_RUN) begin
         tick = st.c.tmr_pre == 16'(HALF_MS - 1);
         d.c.tmr_pre = tick ? 16'h0000 : st.c.tmr_pre + 16'h0001;
      end
      if (tick) begin
         rem_n = st.c.tmr_rem - 7'h01;
         d.c.tmr_rem = rem_n;
         if (rem_n == {1'b0, st.c.tmr_cnt}) begin
            d.c.tmr_pin = ~st.c.tmr_pin;
         end
         if (rem_n == 7'h00) begin
            d.c.tmr_exp = 1'b1;
            if (st.c.tmr_rep) begin
               d.c.tmr_rem = {st.c.tmr_cnt, 1'b0};
               d.c.tmr_pin = 1'b1;
            end else begin
               d.c.tmr_st  = IDR_TMR_OFF;
               d.c.tmr_pin = st.c.tmr_idle;
            end
         end
      end

      // register reads and their side effects
      case (raddr)
         `IDR_OFF_SAP_A:  rd = st.c.sap_a;
         `IDR_OFF_SAP_B:  rd = st.c.sap_b;
         `IDR_OFF_TAM:    rd = st.c.tam;
         `IDR_OFF_TEI_A:  rd = st.c.tei_a;
         `IDR_OFF_TEI_B:  rd = st.c.tei_b;
         `IDR_OFF_LEN_HI: rd = {`IDR_VERSION_VALUE, st.c.rx_lov, st.c.rx_cnt[12:8]};
         `IDR_OFF_LEN_LO: rd = st.c.rx_cnt[7:0];
         `IDR_OFF_TIMER:  rd = 8'h00;
         `IDR_OFF_RDY:    rd = {4'h0, st.c.rdy_code};
         `IDR_OFF_CTL:    rd = {6'h00, st.c.ops};
         `IDR_OFF_IND_RX: rd = {st.c.s_bits_changed, st.c.indication_changed, 2'b00, st.c.ind_cur};
         `IDR_OFF_CMD_TX: rd = {4'h0, st.c.cmd};
         `IDR_OFF_MF_RX:  rd = {2'b00, MF_LOCK, st.c.s_change_irq_enable, st.c.s};
         `IDR_OFF_MF_TX:  rd = {3'b000, st.c.s_change_irq_enable, st.c.q};
         `IDR_OFF_MODE:   rd = {7'h00, st.c.external_transceiver_select};
         default:         rd_hit = 1'b0;
      endcase
      if (rd_go) begin
         d.b.rvalid = 1'b1;
         d.b.rdata  = st.b.soft_reset_bit ? 32'h0000_0000 : {24'h000000, rd};
         d.b.rresp  = (rd_hit & ~st.b.soft_reset_bit) ? `IDR_RESP_OKAY : `IDR_RESP_SLVERR;
         if (raddr == `IDR_OFF_IND_RX) begin
            if (st.c.ind_pend_v) begin
               d.c.ind_cur    = st.c.ind_pend;
               d.c.ind_pend_v = 1'b0;
            end else begin
               d.c.indication_changed = 1'b0;
            end
         end
         if (raddr == `IDR_OFF_MF_RX) begin
            d.c.s_bits_changed = 1'b0;
         end
      end

      // register writes
      case (waddr)
         `IDR_OFF_SAP_A, `IDR_OFF_SAP_B, `IDR_OFF_TAM, `IDR_OFF_TEI_A, `IDR_OFF_TEI_B,
         `IDR_OFF_TIMER, `IDR_OFF_RDY, `IDR_OFF_CTL, `IDR_OFF_CMD_TX, `IDR_OFF_MF_TX,
         `IDR_OFF_MODE:   wr_hit = 1'b1;
         default:         wr_hit = 1'b0;
      endcase
      if (wr_go) begin
         d.b.bvalid = 1'b1;
         d.b.bresp  = (wr_hit & (~st.b.soft_reset_bit | waddr == `IDR_OFF_CTL)) ? `IDR_RESP_OKAY : `IDR_RESP_SLVERR;
      end
      if (wen & waddr == `IDR_OFF_CTL) begin
         d.b.soft_reset_bit = wd[`IDR_CTL_SOFT_RESET_BIT_BIT];
         d.c.ops  = wd[1:0];
      end
      if (wen & ~st.b.soft_reset_bit) begin
         case (waddr)
            `IDR_OFF_SAP_A:  d.c.sap_a = wd;
            `IDR_OFF_SAP_B:  d.c.sap_b = wd;
            `IDR_OFF_TAM:    d.c.tam   = wd;
            `IDR_OFF_TEI_A:  d.c.tei_a = wd;
            `IDR_OFF_TEI_B:  d.c.tei_b = wd;
            `IDR_OFF_RDY:    d.c.rdy_code = wd[3:0];
            `IDR_OFF_CMD_TX: d.c.cmd = wd[3:0];
            `IDR_OFF_MF_TX: begin
               d.c.s_change_irq_enable = wd[`IDR_MF_S_CHANGE_IRQ_ENABLE_BIT];
               d.c.q    = wd[3:0];
            end
            `IDR_OFF_MODE:   d.c.external_transceiver_select = wd[0];
            `IDR_OFF_TIMER: begin
               d.c.tmr_rep  = wd[`IDR_TMR_REPEAT_BIT];
               d.c.tmr_idle = wd[`IDR_TMR_IDLE_BIT];
               d.c.tmr_cnt  = wd[5:0];
               d.c.tmr_pre  = 16'h0000;
               d.c.tmr_exp  = 1'b0;
               if (wd[5:0] == 6'h00) begin
                  d.c.tmr_st  = IDR_TMR_OFF;
                  d.c.tmr_rem = 7'h00;
                  d.c.tmr_pin = wd[`IDR_TMR_IDLE_BIT];
               end else begin
                  d.c.tmr_st  = IDR_TMR_RUN;
                  d.c.tmr_rem = {wd[5:0], 1'b0};
                  d.c.tmr_pin = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // address recognition of a received frame
      if (RX_ADDR_VLD) begin
         d.c.match_vld = 1'b1;
         d.c.match = (RX_ADDR1 == st.c.sap_a | RX_ADDR1 == st.c.sap_b) &
                     (masked_eq(RX_ADDR2, st.c.tei_a, st.c.tam) |
                      masked_eq(RX_ADDR2, st.c.tei_b, st.c.tam) |
                      RX_ADDR2 == `IDR_GROUP_ENDPOINT);
      end

      // frame byte count, frozen from message end until acknowledge
      if (RX_ACK_CMD) begin
         d.c.rx_cnt  = 13'h0000;
         d.c.rx_lov  = 1'b0;
         d.c.rx_done = 1'b0;
      end else if (~st.c.rx_done) begin
         if (RX_BYTE) begin
            d.c.rx_cnt = st.c.rx_cnt + 13'h0001;
            if (st.c.rx_cnt == 13'h1FFF) begin
               d.c.rx_lov = 1'b1;
            end
         end
         if (RX_MSG_END) begin
            d.c.rx_done = 1'b1;
         end
      end

      // indication code: two-deep buffer, change flag set wins over read clear
      ind_src = st.c.external_transceiver_select ? GCI_IND : L1_IND;
      if (ind_src != st.c.ind_last) begin
         d.c.ind_last = ind_src;
         if (~d.c.indication_changed) begin
            d.c.ind_cur = ind_src;
            d.c.indication_changed     = 1'b1;
         end else begin
            d.c.ind_pend   = ind_src;
            d.c.ind_pend_v = 1'b1;
         end
      end
      d.c.active  = st.c.external_transceiver_select & (st.c.ind_cur == st.c.rdy_code);
      d.c.act_req = st.c.external_transceiver_select & (st.c.cmd == `IDR_CMD_AR);

      // multiframe s capture and q transmit
      if (MF_STROBE) begin
         slot = mf_slot(MF_FRAME);
         if (slot[2]) begin
            d.c.q_out = st.c.q[~slot[1:0]];
            d.c.s_shadow[~slot[1:0]] = S_BIT_IN;
            if (slot[1:0] == 2'h3) begin
               s_new = {st.c.s_shadow[3:1], S_BIT_IN};
               d.c.s = s_new;
               if (s_new != st.c.s & st.c.s_change_irq_enable & ~st.c.external_transceiver_select) begin
                  d.c.s_bits_changed = 1'b1;
               end
            end
         end
      end

      // soft reset holds everything but the bus logic at reset values
      if (d.b.soft_reset_bit) begin
         d.c = core_reset();
      end
   end

   // state register
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         st <= '{b: '0, c: CORE_RST};
      end else begin
         st <= d;
      end
   end

   // outputs straight from the state register
   assign AWREADY        = st.b.awready;
   assign WREADY         = st.b.wready;
   assign BVALID         = st.b.bvalid;
   assign BRESP          = st.b.bresp;
   assign ARREADY        = st.b.arready;
   assign RVALID         = st.b.rvalid;
   assign RDATA          = st.b.rdata;
   assign RRESP          = st.b.rresp;
   assign SOFT_RESET     = st.b.soft_reset_bit;
   assign ADDR_MATCH     = st.c.match;
   assign ADDR_MATCH_VLD = st.c.match_vld;
   assign TIMER_OUT      = st.c.tmr_pin;
   assign TIMER_EXPIRED  = st.c.tmr_exp;
   assign PHASE_COMP_SEL = st.c.ops;
   assign CMD_CODE       = st.c.cmd;
   assign ACT_REQ        = st.c.act_req;
   assign LINE_ACTIVE    = st.c.active;
   assign Q_BIT_OUT      = st.c.q_out;

   // checks
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);

   grp_match_a: assert property (
      RX_ADDR_VLD & ~SOFT_RESET & (RX_ADDR1 == st.c.sap_a) & (RX_ADDR2 == `IDR_GROUP_ENDPOINT) & ~d.b.soft_reset_bit
      |=> ADDR_MATCH & ADDR_MATCH_VLD)
      else $error("group endpoint frame not matched");

   len_overflow_a: assert property (
      RX_BYTE & ~RX_ACK_CMD & ~st.c.rx_done & (st.c.rx_cnt == 13'h1FFF) & ~d.b.soft_reset_bit
      |=> st.c.rx_lov && st.c.rx_cnt == 13'h0000)
      else $error("length overflow not flagged");

   len_hold_a: assert property (
      st.c.rx_done & ~RX_ACK_CMD & ~d.b.soft_reset_bit |=> $stable(st.c.rx_cnt) && $stable(st.c.rx_lov))
      else $error("frame length moved before acknowledge");

   timer_start_a: assert property (
      wr_go & WSTRB[0] & (waddr == `IDR_OFF_TIMER) & (WDATA[5:0] != 6'h00) & ~SOFT_RESET & ~d.b.soft_reset_bit
      |=> TIMER_OUT & (st.c.tmr_st == IDR_TMR_RUN) & (st.c.tmr_rem == {$past(WDATA[5:0]), 1'b0}))
      else $error("timer did not start high");

   timer_stop_a: assert property (
      wr_go & WSTRB[0] & (waddr == `IDR_OFF_TIMER) & (WDATA[5:0] == 6'h00) & ~SOFT_RESET
      |=> (st.c.tmr_st == IDR_TMR_OFF) ##1 ~TIMER_EXPIRED)
      else $error("zero count did not stop timer");

   oneshot_end_a: assert property (
      TIMER_EXPIRED & ~st.c.tmr_rep & ~SOFT_RESET & ~$past(wen) |-> (st.c.tmr_st == IDR_TMR_OFF) && TIMER_OUT == st.c.tmr_idle)
      else $error("one-shot timer kept running");

   icc_set_a: assert property (
      (ind_src != st.c.ind_last) & ~d.b.soft_reset_bit |=> st.c.indication_changed)
      else $error("indication change lost");

   scc_gate_a: assert property (
      $rose(st.c.s_bits_changed) |-> $past(st.c.s_change_irq_enable) && !$past(st.c.external_transceiver_select))
      else $error("s change flagged while disabled");

   soft_reset_bit_read_a: assert property (
      rd_go & SOFT_RESET |=> RVALID && RDATA == 32'h0000_0000 && RRESP == `IDR_RESP_SLVERR)
      else $error("register read during soft reset");

   q_frame1_a: assert property (
      MF_STROBE & (MF_FRAME == 5'h01) & ~d.b.soft_reset_bit |=> Q_BIT_OUT == $past(st.c.q[3]))
      else $error("first q bit not in frame 1");
endmodule

// file: inc/idr_consts.svh
// offsets, field positions, reset values and timing figures of the register bank
`ifndef IDR_CONSTS_SVH
`define IDR_CONSTS_SVH
// register byte offsets
`define IDR_OFF_SAP_A    8'h30
`define IDR_OFF_SAP_B    8'h34
`define IDR_OFF_TAM      8'h38
`define IDR_OFF_TEI_A    8'h3C
`define IDR_OFF_TEI_B    8'h40
`define IDR_OFF_LEN_HI   8'h44
`define IDR_OFF_LEN_LO   8'h48
`define IDR_OFF_TIMER    8'h4C
`define IDR_OFF_RDY      8'h50
`define IDR_OFF_CTL      8'h54
`define IDR_OFF_IND_RX   8'h58
`define IDR_OFF_CMD_TX   8'h5C
`define IDR_OFF_MF_RX    8'h60
`define IDR_OFF_MF_TX    8'h64
`define IDR_OFF_MODE     8'h80
// field positions
`define IDR_TMR_REPEAT_BIT 7
`define IDR_TMR_IDLE_BIT   6
`define IDR_CTL_SOFT_RESET_BIT_BIT   5
`define IDR_MF_S_CHANGE_IRQ_ENABLE_BIT    4
// reset values
`define IDR_RST_RDY      4'hC
`define IDR_RST_IND      4'hF
`define IDR_RST_CMD      4'hF
`define IDR_RST_Q        4'hF
`define IDR_RST_S        4'hF
// fixed codes
`define IDR_GROUP_ENDPOINT 8'hFF
`define IDR_IND_DC       4'hF
`define IDR_IND_PU       4'h7
`define IDR_CMD_AR       4'h8
// version field, arbitrary value
`define IDR_VERSION_VALUE 2'h2
// bus answers
`define IDR_RESP_OKAY    2'h0
`define IDR_RESP_SLVERR  2'h2
// timing
`define IDR_CLK_PERIOD_NS 20
`define IDR_MS_NS         1000000
`define IDR_PHASE0_NS     0
`define IDR_PHASE1_NS     260
`define IDR_PHASE2_NS     520
`define IDR_PHASE3_NS     1040
`endif

// file: inc/idr_pkg.sv
// types of the d-channel address, timer and c/i register bank
package idr_pkg;
   typedef enum logic [1:0] {
      IDR_TMR_OFF = 2'b01,
      IDR_TMR_RUN = 2'b10
   } idr_tmr_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        soft_reset_bit;
   } idr_bus_t;

   typedef struct packed {
      logic [7:0]  sap_a;
      logic [7:0]  sap_b;
      logic [7:0]  tam;
      logic [7:0]  tei_a;
      logic [7:0]  tei_b;
      logic        match;
      logic        match_vld;
      logic [12:0] rx_cnt;
      logic        rx_lov;
      logic        rx_done;
      idr_tmr_t    tmr_st;
      logic        tmr_rep;
      logic        tmr_idle;
      logic [5:0]  tmr_cnt;
      logic [6:0]  tmr_rem;
      logic [15:0] tmr_pre;
      logic        tmr_pin;
      logic        tmr_exp;
      logic [3:0]  rdy_code;
      logic [1:0]  ops;
      logic        external_transceiver_select;
      logic        active;
      logic        act_req;
      logic [3:0]  ind_last;
      logic [3:0]  ind_cur;
      logic [3:0]  ind_pend;
      logic        ind_pend_v;
      logic        indication_changed;
      logic [3:0]  cmd;
      logic        s_change_irq_enable;
      logic [3:0]  q;
      logic [3:0]  s_shadow;
      logic [3:0]  s;
      logic        s_bits_changed;
      logic        q_out;
   } idr_core_t;

   typedef struct packed {
      idr_bus_t  b;
      idr_core_t c;
   } idr_state_t;
endpackage

// file: bench/tb_top.sv
// self-checking bench for the d-channel address, timer and c/i register bank
`include "idr_consts.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // bus side
   logic        MCLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic [7:0]  AWADDR, ARADDR, RX_ADDR1, RX_ADDR2;
   logic [31:0] WDATA, RDATA;
   logic [3:0]  WSTRB, L1_IND, GCI_IND, CMD_CODE;
   logic [1:0]  BRESP, RRESP, PHASE_COMP_SEL;
   // line side
   logic        RX_ADDR_VLD, RX_BYTE, RX_MSG_END, RX_ACK_CMD, ADDR_MATCH, ADDR_MATCH_VLD;
   logic        MF_LOCK, MF_STROBE, S_BIT_IN, ACT_REQ, LINE_ACTIVE, Q_BIT_OUT;
   logic        TIMER_OUT, TIMER_EXPIRED, SOFT_RESET;
   logic [4:0]  MF_FRAME;
   // bench state
   int          err_count, comparisons;
   logic [1:0]  resp;
   logic [31:0] rdv;

   // short ms so the timer runs in a few cycles: half step of 4
   idr_regs #(.TIMER_MS_CYCLES(8)) idr_regs_i (.MCLK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
      .WVALID, .WREADY, .BVALID, .BRESP, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RVALID, .RDATA, .RRESP,
      .RREADY, .RX_ADDR_VLD, .RX_ADDR1, .RX_ADDR2, .RX_BYTE, .RX_MSG_END, .RX_ACK_CMD, .ADDR_MATCH,
      .ADDR_MATCH_VLD, .L1_IND, .GCI_IND, .MF_LOCK, .MF_STROBE, .MF_FRAME, .S_BIT_IN, .CMD_CODE, .ACT_REQ,
      .LINE_ACTIVE, .Q_BIT_OUT, .TIMER_OUT, .TIMER_EXPIRED, .PHASE_COMP_SEL, .SOFT_RESET);

   // 50 mhz clock
   initial begin
      MCLK = 1'b0;
      forever #10 MCLK = ~MCLK;
   end

   // compare and count
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // verdict and end of run
   task test_done();
      if (err_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // axi4-lite write, each channel released when taken
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge MCLK);
      AWADDR <= a;
      WDATA <= {24'h000000, d};
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      while (!(aw && w)) begin
         @(posedge MCLK);
         if (AWREADY === 1'b1) AWVALID <= 1'b0;
         if (WREADY === 1'b1) WVALID <= 1'b0;
         aw = aw | (AWREADY === 1'b1);
         w = w | (WREADY === 1'b1);
      end
      while (BVALID !== 1'b1) @(posedge MCLK);
      resp = BRESP;
      BREADY <= 1'b0;
   endtask

   // axi4-lite read
   task rd(input logic [7:0] a);
      @(posedge MCLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      do @(posedge MCLK); while (ARREADY !== 1'b1);
      ARVALID <= 1'b0;
      while (RVALID !== 1'b1) @(posedge MCLK);
      rdv = RDATA;
      resp = RRESP;
      RREADY <= 1'b0;
   endtask

   // read one register and compare its byte
   task rc(input logic [7:0] a, input logic [7:0] e);
      rd(a);
      chk($sformatf("reg %h", a), rdv, {24'h000000, e});
   endtask

   // one-cycle pulse: 0 message end, 1 acknowledge, 2 address valid
   task pls(input int k);
      @(posedge MCLK);
      if (k == 0) RX_MSG_END <= 1'b1;
      else if (k == 1) RX_ACK_CMD <= 1'b1;
      else RX_ADDR_VLD <= 1'b1;
      @(posedge MCLK);
      RX_MSG_END <= 1'b0;
      RX_ACK_CMD <= 1'b0;
      RX_ADDR_VLD <= 1'b0;
   endtask

   // n received bytes back to back
   task bytes(input int n);
      @(posedge MCLK);
      RX_BYTE <= 1'b1;
      repeat (n - 1) @(posedge MCLK);
      @(posedge MCLK);
      RX_BYTE <= 1'b0;
   endtask

   // present an address pair and check the compare result
   task am(input logic [7:0] a1, input logic [7:0] a2, input logic e);
      RX_ADDR1 <= a1;
      RX_ADDR2 <= a2;
      pls(2);
      @(posedge MCLK);
      chk("match valid", ADDR_MATCH_VLD, 1);
      chk("match", ADDR_MATCH, e);
   endtask

   // wait a bounded time for an expiry pulse
   task wexp(input int lim, input logic e);
      int n;
      n = 0;
      while (TIMER_EXPIRED !== 1'b1 && n < lim) begin
         @(posedge MCLK);
         n++;
      end
      chk("expiry seen", TIMER_EXPIRED === 1'b1, e);
      @(posedge MCLK);
   endtask

   // aux bit slots of frames 1, 6, 11, 16 with q bits 1,0,0,0 programmed
   task mf(input logic [3:0] s);
      for (int i = 0; i < 4; i++) begin
         @(posedge MCLK);
         MF_STROBE <= 1'b1;
         MF_FRAME <= 5'(5 * i + 1);
         S_BIT_IN <= s[3 - i];
         @(posedge MCLK);
         MF_STROBE <= 1'b0;
         @(posedge MCLK);
         chk("q bit", Q_BIT_OUT, i == 0);
      end
   endtask

   // watchdog
   initial begin
      repeat (40000) @(posedge MCLK);
      err_count++;
      test_done();
   end

   // main sequence
   initial begin
      {RST, WSTRB, L1_IND, GCI_IND, MF_LOCK} = {1'b1, 4'hF, 4'hF, 4'hF, 1'b1};
      {AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA} = '0;
      {RX_ADDR_VLD, RX_ADDR1, RX_ADDR2, RX_BYTE, RX_MSG_END, RX_ACK_CMD} = '0;
      {MF_STROBE, MF_FRAME, S_BIT_IN} = '0;
      repeat (10) @(posedge MCLK);
      RST <= 1'b0;
      // reset values
      for (int i = 0; i < 5; i++) rc(8'(8'h30 + 4 * i), 8'h00);
      rc(`IDR_OFF_LEN_HI, {`IDR_VERSION_VALUE, 6'h00});
      rc(`IDR_OFF_LEN_LO, 8'h00);
      rc(`IDR_OFF_TIMER, 8'h00);
      rc(`IDR_OFF_RDY, 8'h0C);
      rc(`IDR_OFF_IND_RX, 8'h0F);
      rc(`IDR_OFF_CMD_TX, 8'h0F);
      rc(`IDR_OFF_MF_TX, 8'h0F);
      rd(8'h90);
      chk("unmapped resp", resp, `IDR_RESP_SLVERR);
      // address candidates and mask
      for (int i = 0; i < 5; i++) begin
         wr(8'(8'h30 + 4 * i), 8'(8'hA0 + i));
         rc(8'(8'h30 + 4 * i), 8'(8'hA0 + i));
      end
      wr(`IDR_OFF_TAM, 8'h01);
      am(8'hA0, 8'hA3, 1);
      am(8'hA1, 8'hA4, 1);
      am(8'hA5, 8'hA3, 0);
      am(8'hA0, 8'hA2, 1);
      am(8'hA0, 8'hA6, 0);
      am(8'hA1, 8'hFF, 1);
      // frame length
      bytes(3);
      rc(`IDR_OFF_LEN_LO, 8'h03);
      pls(0);
      bytes(2);
      rc(`IDR_OFF_LEN_LO, 8'h03);
      pls(1);
      rc(`IDR_OFF_LEN_LO, 8'h00);
      bytes(8192);
      pls(0);
      rc(`IDR_OFF_LEN_HI, {`IDR_VERSION_VALUE, 1'b1, 5'h00});
      pls(1);
      rc(`IDR_OFF_LEN_HI, {`IDR_VERSION_VALUE, 6'h00});
      // ms timer
      wr(`IDR_OFF_TIMER, 8'h02);
      chk("timer pin start", TIMER_OUT, 1);
      repeat (10) @(posedge MCLK);
      chk("timer pin half", TIMER_OUT, 0);
      wexp(40, 1);
      chk("timer pin idle", TIMER_OUT, 0);
      wr(`IDR_OFF_TIMER, 8'h81);
      wexp(20, 1);
      wexp(20, 1);
      wr(`IDR_OFF_TIMER, 8'h40);
      chk("timer pin idle high", TIMER_OUT, 1);
      wexp(30, 0);
      wr(`IDR_OFF_TIMER, 8'h03);
      wr(`IDR_OFF_TIMER, 8'h01);
      wexp(14, 1);
      // soft reset and phase select
      wr(`IDR_OFF_RDY, 8'h05);
      wr(`IDR_OFF_CTL, 8'h20);
      chk("soft reset out", SOFT_RESET, 1);
      chk("ctl write resp", resp, `IDR_RESP_OKAY);
      rd(`IDR_OFF_RDY);
      chk("inhibited resp", resp, `IDR_RESP_SLVERR);
      chk("inhibited data", rdv, 0);
      wr(`IDR_OFF_RDY, 8'h05);
      chk("inhibited write", resp, `IDR_RESP_SLVERR);
      wr(`IDR_OFF_CTL, 8'h00);
      rc(`IDR_OFF_RDY, 8'h0C);
      for (int i = 0; i < 4; i++) begin
         wr(`IDR_OFF_CTL, 8'(i));
         chk("phase select", PHASE_COMP_SEL, i);
         rc(`IDR_OFF_CTL, 8'(i));
      end
      // s and q bits
      wr(`IDR_OFF_MF_TX, 8'h18);
      mf(4'hA);
      rc(`IDR_OFF_IND_RX, 8'h8F);
      rc(`IDR_OFF_IND_RX, 8'h8F);
      rc(`IDR_OFF_MF_RX, 8'h3A);
      rc(`IDR_OFF_MF_RX, 8'h3A);
      rc(`IDR_OFF_IND_RX, 8'h0F);
      wr(`IDR_OFF_MF_TX, 8'h08);
      mf(4'h5);
      rc(`IDR_OFF_IND_RX, 8'h0F);
      rc(`IDR_OFF_MF_RX, 8'h25);
      // indications
      L1_IND <= 4'h3;
      repeat (3) @(posedge MCLK);
      rc(`IDR_OFF_IND_RX, 8'h43);
      rc(`IDR_OFF_IND_RX, 8'h03);
      L1_IND <= 4'h5;
      repeat (3) @(posedge MCLK);
      L1_IND <= 4'h6;
      repeat (3) @(posedge MCLK);
      rc(`IDR_OFF_IND_RX, 8'h45);
      rc(`IDR_OFF_IND_RX, 8'h46);
      rc(`IDR_OFF_IND_RX, 8'h06);
      // external transceiver mode
      wr(`IDR_OFF_MODE, 8'h01);
      rc(`IDR_OFF_IND_RX, 8'h4F);
      GCI_IND <= `IDR_IND_PU;
      repeat (3) @(posedge MCLK);
      rc(`IDR_OFF_IND_RX, 8'h47);
      wr(`IDR_OFF_CMD_TX, {4'h0, `IDR_CMD_AR});
      chk("command code", CMD_CODE, `IDR_CMD_AR);
      @(posedge MCLK);
      chk("activate request", ACT_REQ, 1);
      rc(`IDR_OFF_CMD_TX, 8'h08);
      GCI_IND <= 4'hC;
      repeat (3) @(posedge MCLK);
      chk("line active", LINE_ACTIVE, 1);
      wr(`IDR_OFF_RDY, 8'h05);
      repeat (3) @(posedge MCLK);
      chk("line inactive", LINE_ACTIVE, 0);
      // s change in transceiver mode leaves the flag clear
      wr(`IDR_OFF_MF_TX, 8'h18);
      mf(4'h3);
      rc(`IDR_OFF_IND_RX, 8'h4C);
      test_done();
   end
endmodule
